// *** hw/fcf_device.sv ***
// Device end: command framing, configuration and status registers
`timescale 1ns/1ps
module fcf_device
   import fcf_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   fcf_spi_if.device        spi,
   input  wire logic        core_erase_busy,
   input  wire logic        core_program_busy,
   input  wire logic        program_fail,
   input  wire logic        erase_fail,
   output logic             exec_valid,
   output logic [7:0]       exec_opcode,
   output logic [24:0]      exec_addr,
   output logic             write_enable_latch,
   output logic             current_address_width,
   output logic [6:0]       drive_pct,
   output logic [3:0]       dummy_dual,
   output logic [3:0]       dummy_quad,
   output logic [7:0]       status_two,
   output logic [7:0]       status_three
);
   logic [2:0]  sclk_s_q, cs_s_q, si_s_q;
   logic        sclk_f_q, cs_f_q;
   logic        sclk_rise, sclk_fall, cs_fall, cs_rise;
   logic [15:0] bitcnt_q;
   logic [7:0]  bytes_q;
   logic [6:0]  shift_q;
   logic [7:0]  opcode_q;
   logic [31:0] addr_q;
   logic        rd_q;
   logic [7:0]  out_q;
   logic        so_q;
   logic        init_q;
   logic        rst_arm_q;
   logic [2:0]  lock_q;
   logic        erase_sus_q, prog_sus_q;
   logic        prog_err_q, erase_err_q;
   logic [1:0]  dummy_q, drv_q;
   logic        pwr_addr_q;
   logic        upper_address_bit_q;
   logic        addr4_q;
   logic        wel_q;
   logic        byte_done, aligned, soft_rst, do_exec;
   logic [7:0]  new_byte;
   logic [7:0]  addr_len;
   logic [7:0]  ear_val;

   // Three-stage pin synchronisers; a clock or select level counts once stages two and three agree
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sclk_s_q <= 3'h0;
         cs_s_q   <= 3'h7;
         si_s_q   <= 3'h0;
         sclk_f_q <= 1'b0;
         cs_f_q   <= 1'b1;
      end else begin
         sclk_s_q <= {sclk_s_q[1:0], spi.sclk};
         cs_s_q   <= {cs_s_q[1:0], spi.cs_n};
         si_s_q   <= {si_s_q[1:0], spi.si};
         if (sclk_s_q[1] == sclk_s_q[2]) sclk_f_q <= sclk_s_q[2];
         if (cs_s_q[1] == cs_s_q[2]) cs_f_q <= cs_s_q[2];
      end
   end

   assign sclk_rise = sclk_s_q[1] & sclk_s_q[2] & ~sclk_f_q & ~cs_f_q;
   assign sclk_fall = ~sclk_s_q[1] & ~sclk_s_q[2] & sclk_f_q & ~cs_f_q;
   assign cs_fall   = ~cs_s_q[1] & ~cs_s_q[2] & cs_f_q;
   assign cs_rise   = cs_s_q[1] & cs_s_q[2] & ~cs_f_q;

   assign new_byte  = {shift_q, si_s_q[2]};
   assign byte_done = sclk_rise && (bitcnt_q[2:0] == 3'h7);
   assign aligned   = (bitcnt_q[2:0] == 3'h0) && (bitcnt_q != 16'h0);
   assign addr_len  = (addr4_q || opcode_q == OP_PP4 || opcode_q == OP_SE4 ||
                       opcode_q == OP_BE32_4) ? 8'd4 : 8'd3;
   assign soft_rst  = cs_rise && aligned && bytes_q == 8'd1 && opcode_q == OP_RST && rst_arm_q;
   assign ear_val   = {7'h0, upper_address_bit_q};

   // Serial input framing, MSB first
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bitcnt_q <= 16'h0;
         bytes_q  <= 8'h0;
         shift_q  <= 7'h0;
         opcode_q <= 8'h0;
         addr_q   <= 32'h0;
      end else if (cs_fall) begin
         bitcnt_q <= 16'h0;
         bytes_q  <= 8'h0;
         addr_q   <= 32'h0;
      end else if (sclk_rise) begin
         bitcnt_q <= bitcnt_q + 16'h1;
         shift_q  <= new_byte[6:0];
         if (byte_done) begin
            if (bytes_q != 8'hFF) bytes_q <= bytes_q + 8'h1;
            if (bytes_q == 8'h0) opcode_q <= new_byte;
            else if (bytes_q <= addr_len) addr_q <= {addr_q[23:0], new_byte};
         end
      end
   end

   // Read-out of registers on falling serial clock
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rd_q  <= 1'b0;
         out_q <= 8'h0;
         so_q  <= 1'b0;
      end else if (cs_rise || cs_fall) begin
         rd_q <= 1'b0;
      end else if (byte_done && bytes_q == 8'h0) begin
         rd_q <= 1'b1;
         case (new_byte)
            OP_RD_SR2: out_q <= status_two;
            OP_RD_SR3: out_q <= status_three;
            OP_RD_UAR: out_q <= ear_val;
            default:   rd_q  <= 1'b0;
         endcase
      end else if (sclk_fall && rd_q) begin
         so_q  <= out_q[7];
         out_q <= {out_q[6:0], out_q[7]};
      end
   end

   assign spi.so    = so_q;
   assign spi.so_oe = rd_q & ~cs_f_q;

   // Reset-enable arming for the two-command reset
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) rst_arm_q <= 1'b0;
      else if (cs_rise && bitcnt_q != 16'h0)
         rst_arm_q <= aligned && bytes_q == 8'd1 && opcode_q == OP_RST_EN;
   end

   // Address mode and upper address bit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         init_q              <= 1'b0;
         addr4_q             <= 1'b0;
         upper_address_bit_q <= 1'b0;
      end else if (!init_q || soft_rst) begin
         init_q              <= 1'b1;
         addr4_q             <= pwr_addr_q;
         upper_address_bit_q <= 1'b0;
      end else if (cs_rise && aligned) begin
         if (opcode_q == OP_EN4B) addr4_q <= 1'b1;
         if (opcode_q == OP_EX4B) addr4_q <= 1'b0;
         if (opcode_q == OP_WR_UAR && bytes_q >= 8'd2)
            upper_address_bit_q <= addr_q[0];
      end
   end

   // Suspend flags
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         erase_sus_q <= 1'b0;
         prog_sus_q  <= 1'b0;
      end else if (soft_rst) begin
         erase_sus_q <= 1'b0;
         prog_sus_q  <= 1'b0;
      end else if (cs_rise && aligned && bytes_q == 8'd1) begin
         if (opcode_q == OP_SUSPEND) begin
            if (core_erase_busy) erase_sus_q <= 1'b1;
            if (core_program_busy) prog_sus_q <= 1'b1;
         end else if (opcode_q == OP_RESUME) begin
            erase_sus_q <= 1'b0;
            prog_sus_q  <= 1'b0;
         end
      end
   end

   // Error flags; a failure in the resume cycle wins
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prog_err_q  <= 1'b0;
         erase_err_q <= 1'b0;
      end else begin
         if (program_fail) prog_err_q <= 1'b1;
         else if (cs_rise && aligned && opcode_q == OP_RESUME) prog_err_q <= 1'b0;
         if (erase_fail) erase_err_q <= 1'b1;
         else if (cs_rise && aligned && opcode_q == OP_RESUME) erase_err_q <= 1'b0;
      end
   end

   // Write enable latch and writable configuration
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wel_q      <= 1'b0;
         lock_q     <= LOCK_RST;
         drv_q      <= DRV_RST;
         dummy_q    <= DUMMY_RST;
         pwr_addr_q <= PWR_ADDR_RST;
      end else if (soft_rst) begin
         wel_q <= 1'b0;
      end else if (cs_rise && aligned) begin
         case (opcode_q)
            OP_WREN: if (bytes_q == 8'd1) wel_q <= 1'b1;
            OP_WRDI: if (bytes_q == 8'd1) wel_q <= 1'b0;
            OP_WR_SR2: if (wel_q && bytes_q == 8'd2) begin
               lock_q <= lock_q | addr_q[SR2_LOCK_HI:SR2_LOCK_LO];
               wel_q  <= 1'b0;
            end
            OP_WR_SR3: if (wel_q && bytes_q == 8'd2) begin
               drv_q      <= addr_q[SR3_DRV_HI:SR3_DRV_LO];
               pwr_addr_q <= addr_q[SR3_PWR_ADDR];
               dummy_q    <= addr_q[SR3_DUMMY_HI:SR3_DUMMY_LO];
               wel_q      <= 1'b0;
            end
            default: if (do_exec && opcode_q != OP_DPD) wel_q <= 1'b0;
         endcase
      end
   end

   // Program and erase dispatch; a partial byte rejects and keeps the latch
   always_comb begin
      do_exec = 1'b0;
      if (cs_rise && aligned) begin
         if (opcode_q == OP_DPD) do_exec = (bytes_q == 8'd1);
         else if (fcf_is_pe(opcode_q) && wel_q) begin
            if (opcode_q == OP_CE || opcode_q == OP_CE_ALT) do_exec = (bytes_q == 8'd1);
            else if (opcode_q == OP_PP || opcode_q == OP_PP4) do_exec = (bytes_q > addr_len + 8'd1);
            else do_exec = (bytes_q == addr_len + 8'd1);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         exec_valid  <= 1'b0;
         exec_opcode <= 8'h0;
         exec_addr   <= 25'h0;
      end else begin
         exec_valid <= do_exec;
         if (do_exec) begin
            exec_opcode <= opcode_q;
            if (addr_len == 8'd4) exec_addr <= addr_q[24:0];
            else exec_addr <= {upper_address_bit_q, addr_q[23:0]};
         end
      end
   end

   assign write_enable_latch    = wel_q;
   assign current_address_width = addr4_q;
   assign drive_pct  = fcf_drive_pct(drv_q);
   assign dummy_dual = dummy_q[0] ? DUMMY_DUAL_HI : DUMMY_DUAL_LO;
   assign dummy_quad = dummy_q[0] ? DUMMY_QUAD_HI : DUMMY_QUAD_LO;
   assign status_two   = {erase_sus_q, 1'b0, lock_q, prog_sus_q, 1'b1, addr4_q};
   assign status_three = {1'b0, drv_q, pwr_addr_q, erase_err_q, prog_err_q, dummy_q};
endmodule // fcf_device

// *** hw/fcf_host.sv ***
// Host end: serial clock generator and bit shifter for command sequences
`timescale 1ns/1ps
module fcf_host
   import fcf_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   fcf_spi_if.host          spi,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [7:0]  req_bits,
   input  wire logic [39:0] req_tx,
   output logic             done,
   output logic [31:0]      rx_data
);
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} fcf_hstate_type;
   fcf_hstate_type state_q;
   logic [7:0]  phase_q;
   logic [7:0]  left_q;
   logic [39:0] tx_q;
   logic        cs_n_q, sclk_q, si_q;
   logic [2:0]  so_s_q;
   logic        so_f_q;
   logic        half_end;

   assign half_end  = (phase_q == 8'(HOST_HALF_CYC - 1));
   assign req_ready = (state_q == H_IDLE);

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         so_s_q <= 3'h0;
         so_f_q <= 1'b0;
      end else begin
         so_s_q <= {so_s_q[1:0], spi.so};
         if (so_s_q[1] == so_s_q[2]) so_f_q <= so_s_q[2];
      end
   end

   // Sequence: opcode and bytes MSB first, select raised after the last bit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= H_IDLE;
         phase_q <= 8'h0;
         left_q  <= 8'h0;
         tx_q    <= 40'h0;
         cs_n_q  <= 1'b1;
         sclk_q  <= 1'b0;
         si_q    <= 1'b0;
         done    <= 1'b0;
         rx_data <= 32'h0;
      end else begin
         done    <= 1'b0;
         phase_q <= half_end ? 8'h0 : phase_q + 8'h1;
         case (state_q)
            H_IDLE: begin
               phase_q <= 8'h0;
               if (req_valid && req_bits != 8'h0) begin
                  state_q <= H_SETUP;
                  cs_n_q  <= 1'b0;
                  left_q  <= req_bits;
                  tx_q    <= req_tx;
                  si_q    <= req_tx[39];
               end
            end
            H_SETUP: if (half_end) state_q <= H_HIGH;
            H_LOW: if (half_end) state_q <= H_HIGH;
            H_HIGH: begin
               if (phase_q == 8'h0) sclk_q <= 1'b1;
               if (half_end) begin
                  sclk_q  <= 1'b0;
                  rx_data <= {rx_data[30:0], so_f_q};
                  tx_q    <= {tx_q[38:0], 1'b0};
                  si_q    <= tx_q[38];
                  left_q  <= left_q - 8'h1;
                  state_q <= (left_q == 8'h1) ? H_HOLD : H_LOW;
               end
            end
            H_HOLD: if (half_end) begin
               cs_n_q  <= 1'b1;
               state_q <= H_GAP;
            end
            H_GAP: if (half_end) begin
               done    <= 1'b1;
               state_q <= H_IDLE;
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

   assign spi.cs_n = cs_n_q;
   assign spi.sclk = sclk_q;
   assign spi.si   = si_q;
endmodule // fcf_host

// *** hw/fcf_pkg.sv ***
// Shared constants for the flash configuration and command front end
package fcf_pkg;
   // Opcodes
   localparam logic [7:0] OP_WREN    = 8'h06;
   localparam logic [7:0] OP_WRDI    = 8'h04;
   localparam logic [7:0] OP_RD_SR2  = 8'h35;
   localparam logic [7:0] OP_RD_SR3  = 8'h15;
   localparam logic [7:0] OP_WR_SR2  = 8'h31;
   localparam logic [7:0] OP_WR_SR3  = 8'h11;
   localparam logic [7:0] OP_RD_UAR  = 8'hC8;
   localparam logic [7:0] OP_WR_UAR  = 8'hC5;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME  = 8'h7A;
   localparam logic [7:0] OP_RST_EN  = 8'h66;
   localparam logic [7:0] OP_RST     = 8'h99;
   localparam logic [7:0] OP_EN4B    = 8'hB7;
   localparam logic [7:0] OP_EX4B    = 8'hE9;
   localparam logic [7:0] OP_PP      = 8'h02;
   localparam logic [7:0] OP_PP4     = 8'h12;
   localparam logic [7:0] OP_SE      = 8'h20;
   localparam logic [7:0] OP_SE4     = 8'h21;
   localparam logic [7:0] OP_BE32    = 8'h52;
   localparam logic [7:0] OP_BE32_4  = 8'h5C;
   localparam logic [7:0] OP_CE      = 8'hC7;
   localparam logic [7:0] OP_CE_ALT  = 8'h60;
   localparam logic [7:0] OP_DPD     = 8'hB9;
   // status_register_two bit positions
   localparam int SR2_ERASE_SUS = 7;
   localparam int SR2_LOCK_HI   = 5;
   localparam int SR2_LOCK_LO   = 3;
   localparam int SR2_PROG_SUS  = 2;
   localparam int SR2_QUAD_EN   = 1;
   localparam int SR2_ADDR_W    = 0;
   // status_register_three bit positions
   localparam int SR3_DRV_HI    = 6;
   localparam int SR3_DRV_LO    = 5;
   localparam int SR3_PWR_ADDR  = 4;
   localparam int SR3_ERASE_ERR = 3;
   localparam int SR3_PROG_ERR  = 2;
   localparam int SR3_DUMMY_HI  = 1;
   localparam int SR3_DUMMY_LO  = 0;
   // Reset values
   localparam logic [2:0] LOCK_RST     = 3'h0;
   localparam logic [1:0] DRV_RST      = 2'h1;
   localparam logic [1:0] DUMMY_RST    = 2'h0;
   localparam logic       PWR_ADDR_RST = 1'b0;
   // Dummy cycle counts
   localparam logic [3:0] DUMMY_DUAL_LO = 4'h4;
   localparam logic [3:0] DUMMY_DUAL_HI = 4'h8;
   localparam logic [3:0] DUMMY_QUAD_LO = 4'h6;
   localparam logic [3:0] DUMMY_QUAD_HI = 4'hA;
   // Host serial clock timing
   localparam int CLK_NS        = 8;
   localparam int HOST_HALF_NS  = 64;
   localparam int HOST_HALF_CYC = (HOST_HALF_NS + CLK_NS - 1) / CLK_NS;

   function automatic logic [6:0] fcf_drive_pct(input logic [1:0] sel);
      case (sel)
         2'h0:    fcf_drive_pct = 7'd100;
         2'h1:    fcf_drive_pct = 7'd75;
         2'h2:    fcf_drive_pct = 7'd50;
         default: fcf_drive_pct = 7'd25;
      endcase
   endfunction

   function automatic logic fcf_is_pe(input logic [7:0] op);
      fcf_is_pe = (op == OP_PP) || (op == OP_PP4) || (op == OP_SE) || (op == OP_SE4) ||
                  (op == OP_BE32) || (op == OP_BE32_4) || (op == OP_CE) || (op == OP_CE_ALT);
   endfunction
endpackage

// *** hw/fcf_spi_if.sv ***
// Serial flash link between host controller and device
`timescale 1ns/1ps
interface fcf_spi_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so;
   logic so_oe;
   modport device (input cs_n, input sclk, input si, output so, output so_oe);
   modport host   (output cs_n, output sclk, output si, input so, input so_oe);
endinterface

// *** tb/fcf_link_monitor.sv ***
// Assertions on the serial link between host and device ends
`timescale 1ns/1ps
module fcf_link_monitor (
   input logic clk_sys,
   input logic rstn,
   input logic cs_n,
   input logic sclk,
   input logic si,
   input logic so,
   input logic so_oe
);
   default clocking mon_cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   // Host clock: seven samples high, nine low, first rise nine samples after select
   sequence high_phase;
      sclk [*7] ##1 !sclk;
   endsequence

   sequence low_phase;
      !sclk [*8];
   endsequence

   sequence first_rise;
      low_phase ##1 !sclk ##1 sclk;
   endsequence

   sclk_idle_a: assert property (cs_n |-> !sclk)
      else $error("serial clock active while deselected");
   cs_setup_a: assert property ($fell(cs_n) |-> first_rise)
      else $error("first clock rise not nine cycles after select");
   pulse_high_a: assert property ($rose(sclk) |-> high_phase)
      else $error("serial clock high phase wrong length");
   pulse_low_a: assert property ($fell(sclk) |-> low_phase)
      else $error("serial clock low phase too short");
   si_stable_a: assert property (sclk && $past(sclk) |-> $stable(si))
      else $error("serial input moved while clock high");
   cs_hold_a: assert property ($rose(cs_n) |-> $past(sclk, 9) && !$past(sclk, 8))
      else $error("select raised off the hold point");
   deselect_a: assert property ($rose(cs_n) |-> ##[0:8] !so_oe)
      else $error("device kept driving after deselect");
   so_start_a: assert property ($rose(so_oe) |-> !cs_n && sclk)
      else $error("device began driving outside the last opcode clock pulse");
   so_stable_a: assert property (so_oe && sclk && $past(sclk) |-> $stable(so))
      else $error("serial output moved while clock high");

   read_cov: cover property ($rose(so_oe));
endmodule // fcf_link_monitor

// *** tb/flash_config_and_command_frontend_tb_top.sv ***
// Self-checking bench joining host and device ends over the serial link
`timescale 1ns/1ps
module flash_config_and_command_frontend_tb_top;
   import fcf_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic        req_valid = 1'b0;
   logic [7:0]  req_bits = 8'h00;
   logic [39:0] req_tx = 40'h0;
   logic        core_erase_busy = 1'b0;
   logic        core_program_busy = 1'b0;
   logic        program_fail = 1'b0;
   logic        erase_fail = 1'b0;
   logic        req_ready, done, exec_valid, write_enable_latch, current_address_width;
   logic [31:0] rx_data;
   logic [7:0]  exec_opcode, status_two, status_three;
   logic [24:0] exec_addr;
   logic [6:0]  drive_pct;
   logic [3:0]  dummy_dual, dummy_quad;
   logic [8:0]  rd_q[$];
   logic [32:0] ex_q[$];
   logic [8:0]  note;
   logic [32:0] ex;
   logic [31:0] seed = 32'h25D9;
   int          fail_count = 0;
   int          num_checks = 0;

   always #4 clk_sys = ~clk_sys;

   fcf_spi_if fcf_spi_if_inst ();
   fcf_host fcf_host_inst (.clk_sys(clk_sys), .rstn(rstn), .spi(fcf_spi_if_inst), .req_valid(req_valid),
      .req_ready(req_ready), .req_bits(req_bits), .req_tx(req_tx), .done(done), .rx_data(rx_data));
   fcf_device fcf_device_inst (.clk_sys(clk_sys), .rstn(rstn), .spi(fcf_spi_if_inst),
      .core_erase_busy(core_erase_busy), .core_program_busy(core_program_busy), .program_fail(program_fail),
      .erase_fail(erase_fail), .exec_valid(exec_valid), .exec_opcode(exec_opcode), .exec_addr(exec_addr),
      .write_enable_latch(write_enable_latch), .current_address_width(current_address_width),
      .drive_pct(drive_pct), .dummy_dual(dummy_dual), .dummy_quad(dummy_quad),
      .status_two(status_two), .status_three(status_three));
   fcf_link_monitor fcf_link_monitor_inst (.clk_sys(clk_sys), .rstn(rstn), .cs_n(fcf_spi_if_inst.cs_n),
      .sclk(fcf_spi_if_inst.sclk), .si(fcf_spi_if_inst.si), .so(fcf_spi_if_inst.so),
      .so_oe(fcf_spi_if_inst.so_oe));

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One framed sequence; read notes are queued for the watcher
   task automatic xfer(input logic [7:0] bits, input logic [39:0] tx, input logic rd, input logic [7:0] exp);
      int n;
      rd_q.push_back({rd, exp});
      @(posedge clk_sys);
      #1;
      req_bits = bits;
      req_tx = tx;
      req_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("host done", 32'h1, {31'h0, done});
      repeat (4) @(posedge clk_sys);
      #1;
   endtask

   task automatic cmd(input logic [7:0] op);
      xfer(8'd8, {op, 32'h0}, 1'b0, 8'h00);
   endtask

   task automatic rdr(input logic [7:0] op, input logic [7:0] exp);
      xfer(8'd16, {op, 32'h0}, 1'b1, exp);
   endtask

   task automatic wrr(input logic [7:0] op, input logic [7:0] d);
      cmd(OP_WREN);
      xfer(8'd16, {op, d, 24'h0}, 1'b0, 8'h00);
   endtask

   task automatic test_end(input string s);
      $display("test %s done", s);
   endtask

   always @(negedge clk_sys) begin
      if (done === 1'b1 && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         if (note[8]) chk("read data", {24'h0, note[7:0]}, {24'h0, rx_data[7:0]});
      end
      if (exec_valid === 1'b1) begin
         if (ex_q.size() == 0) begin
            chk("unexpected exec", 32'h0, 32'h1);
         end else begin
            ex = ex_q.pop_front();
            chk("exec opcode", {24'h0, ex[32:25]}, {24'h0, exec_opcode});
            chk("exec address", {7'h0, ex[24:0]}, {7'h0, exec_addr});
         end
      end
   end

   initial begin
      #600000;
      fail_count++;
      tally_and_finish();
   end

   initial begin
      logic [7:0] d;
      logic [1:0] s;
      repeat (10) @(posedge clk_sys);
      #1 rstn = 1'b1;
      repeat (4) @(posedge clk_sys);
      rdr(OP_RD_SR2, 8'h02);
      rdr(OP_RD_SR3, 8'h20);
      rdr(OP_RD_UAR, 8'h00);
      chk("status two", 32'h02, {24'h0, status_two});
      chk("status three", 32'h20, {24'h0, status_three});
      chk("host ready", 32'h1, {31'h0, req_ready});
      chk("address width", 32'h0, {31'h0, current_address_width});
      test_end("reset values");
      xfer(8'd16, {OP_WR_SR2, 8'h08, 24'h0}, 1'b0, 8'h00);
      rdr(OP_RD_SR2, 8'h02);
      xfer(8'd9, {OP_WREN, 32'h0}, 1'b0, 8'h00);
      chk("latch after 9 pulses", 32'h0, {31'h0, write_enable_latch});
      cmd(OP_WREN);
      chk("latch after enable", 32'h1, {31'h0, write_enable_latch});
      cmd(OP_WRDI);
      chk("latch after disable", 32'h0, {31'h0, write_enable_latch});
      test_end("refusals");
      wrr(OP_WR_SR2, 8'h08);
      rdr(OP_RD_SR2, 8'h0A);
      wrr(OP_WR_SR2, 8'h00);
      rdr(OP_RD_SR2, 8'h0A);
      wrr(OP_WR_SR2, 8'h30);
      rdr(OP_RD_SR2, 8'h3A);
      test_end("lock bits");
      for (int i = 0; i < 4; i++) begin
         s = i[1:0];
         d = {1'b0, s, 3'b000, s};
         wrr(OP_WR_SR3, d);
         rdr(OP_RD_SR3, d);
         chk("drive", 32'(100 - 25 * i), {25'h0, drive_pct});
         chk("dual dummy", s[0] ? 32'h8 : 32'h4, {28'h0, dummy_dual});
         chk("quad dummy", s[0] ? 32'hA : 32'h6, {28'h0, dummy_quad});
      end
      test_end("drive and dummy");
      xfer(8'd16, {OP_WR_UAR, 8'h01, 24'h0}, 1'b0, 8'h00);
      rdr(OP_RD_UAR, 8'h01);
      cmd(OP_WREN);
      ex_q.push_back({OP_PP, 25'h1123456});
      xfer(8'd40, {OP_PP, 24'h123456, 8'hA5}, 1'b0, 8'h00);
      cmd(OP_WREN);
      xfer(8'd39, {OP_PP, 24'h123456, 8'hA5}, 1'b0, 8'h00);
      chk("latch after partial program", 32'h1, {31'h0, write_enable_latch});
      for (int k = 0; k < 3; k++) begin
         seed = lfsr_next(seed);
         cmd(OP_WREN);
         ex_q.push_back({OP_SE, 1'b1, seed[23:0]});
         xfer(8'd32, {OP_SE, seed[23:0], 8'h00}, 1'b0, 8'h00);
      end
      test_end("three byte mode");
      cmd(OP_EN4B);
      rdr(OP_RD_SR2, 8'h3B);
      chk("address width", 32'h1, {31'h0, current_address_width});
      cmd(OP_WREN);
      ex_q.push_back({OP_SE, 25'h0ABCDEF});
      xfer(8'd40, {OP_SE, 32'h00ABCDEF}, 1'b0, 8'h00);
      cmd(OP_CE);
      cmd(OP_WREN);
      ex_q.push_back({OP_CE, 25'h0});
      cmd(OP_CE);
      ex_q.push_back({OP_DPD, 25'h0});
      cmd(OP_DPD);
      test_end("four byte mode");
      core_erase_busy = 1'b1;
      cmd(OP_SUSPEND);
      rdr(OP_RD_SR2, 8'hBB);
      core_erase_busy = 1'b0;
      core_program_busy = 1'b1;
      cmd(OP_SUSPEND);
      rdr(OP_RD_SR2, 8'hBF);
      cmd(OP_RESUME);
      rdr(OP_RD_SR2, 8'h3B);
      program_fail = 1'b1;
      @(posedge clk_sys);
      #1 program_fail = 1'b0;
      rdr(OP_RD_SR3, 8'h67);
      erase_fail = 1'b1;
      @(posedge clk_sys);
      #1 erase_fail = 1'b0;
      rdr(OP_RD_SR3, 8'h6F);
      cmd(OP_RESUME);
      rdr(OP_RD_SR3, 8'h63);
      cmd(OP_SUSPEND);
      cmd(OP_RST_EN);
      cmd(OP_RST);
      core_program_busy = 1'b0;
      rdr(OP_RD_SR2, 8'h3A);
      test_end("suspend and errors");
      xfer(8'd12, {OP_RD_SR2, 32'h0}, 1'b0, 8'h00);
      rdr(OP_RD_SR2, 8'h3A);
      test_end("read abort");
      wrr(OP_WR_SR3, 8'h73);
      rdr(OP_RD_SR3, 8'h73);
      cmd(OP_RST_EN);
      cmd(OP_RST);
      chk("address width", 32'h1, {31'h0, current_address_width});
      rdr(OP_RD_SR2, 8'h3B);
      cmd(OP_EX4B);
      chk("address width", 32'h0, {31'h0, current_address_width});
      test_end("power-up width");
      repeat (20) @(posedge clk_sys);
      chk("pending exec", 32'h0, 32'(ex_q.size()));
      tally_and_finish();
   end
endmodule // flash_config_and_command_frontend_tb_top
